//--- verilog/gpd_command_decoder.sv
// Command decoder for cyclic output process data of a two-jaw gripper.
// Assumes process data fields are synchronous to clock and held stable.
`timescale 1ns/10ps
`include "gpd_map.svh"
module gpd_command_decoder
  import gpd_pkg::*;
#(
  parameter int FAULTS = 8,
  parameter logic [FAULTS-1:0] RESETTABLE = 8'h7F,
  parameter bit REDUCED = 1'b0,
  parameter int HOLD_CYCLES = `GPD_HOLD_CYCLES
) (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Cyclic process data from the controller
  input wire logic [15:0] commandWord,
  input wire logic [7:0] travelModeSelect,
  input wire logic [7:0] recipeNumber,
  input wire logic [7:0] positionWindow,
  input wire logic [7:0] forceLevel,
  input wire logic [15:0] expectedPartPosition,
  // Mechanics feedback
  input wire logic [15:0] actualPosition,
  input wire logic moveDone,
  input wire logic relearnDone,
  input wire logic partLost,
  input wire logic [FAULTS-1:0] faultEvent,
  // Status toward the controller
  output logic datasetTakenFlag,
  output logic dirOuterFlag,
  output logic dirInnerFlag,
  output logic errorFlag,
  output logic partInWindow,
  output logic partLostMsg,
  output logic [FAULTS-1:0] faultState,
  // Drive control
  output logic moveOuter,
  output logic moveInner,
  output logic forceControlled,
  output logic currentHold,
  output logic relearnBusy,
  // Active data set
  output logic [7:0] activeMode,
  output logic [7:0] activeForce,
  output logic [7:0] activeWindow,
  output logic [15:0] activeTarget
);
  localparam int SLOTS = `GPD_RECIPE_SLOTS;
  gpd_state_t state, next_state;
  logic [15:0] lastCmd;
  logic [23:0] holdCount, next_holdCount;
  logic next_datasetTakenFlag, next_dirOuterFlag, next_dirInnerFlag;
  logic next_partInWindow, next_partLostMsg, next_moveOuter, next_moveInner;
  logic next_forceControlled, next_currentHold, next_relearnBusy;
  logic [FAULTS-1:0] next_faultState;
  logic [7:0] next_activeMode, next_activeForce, next_activeWindow;
  logic [15:0] next_activeTarget;
  // Recipe store; a slot only loads after it has been written once
  logic [7:0] memMode [SLOTS];
  logic [7:0] memForce [SLOTS];
  logic [7:0] memWindow [SLOTS];
  logic [15:0] memTarget [SLOTS];
  logic [SLOTS-1:0] slotUsed, next_slotUsed;
  logic storeWe, captureWe, cmdNew, cmdOk, fire, recipeOk, recipeLive;
  logic [4:0] slot;
  logic [15:0] posDiff;
  function automatic logic modeLegal(input logic [7:0] m);
    case (m)
      `GPD_MODE_OUT, `GPD_MODE_IN, `GPD_MODE_UNI: modeLegal = 1'b1;
      `GPD_MODE_OUT_HOLD, `GPD_MODE_IN_HOLD, `GPD_MODE_UNI_HOLD:
        modeLegal = !REDUCED;
      default: modeLegal = 1'b0;
    endcase
  endfunction
  function automatic logic forceLegal(input logic [7:0] f);
    forceLegal = f >= `GPD_FORCE_MIN && f <= `GPD_FORCE_MAX;
  endfunction
  always_comb begin
    // Commands act once, on the cycle the word takes a new value
    cmdNew = commandWord != lastCmd;
    cmdOk = commandWord != `GPD_CMD_NONE
      && (commandWord & (commandWord - 16'h0001)) == 16'h0000
      && (commandWord & ~`GPD_CMD_MASK) == 16'h0000;
    fire = cmdNew && cmdOk;
    recipeLive = recipeNumber == `GPD_RECIPE_LIVE;
    recipeOk = !recipeLive && recipeNumber <= `GPD_RECIPE_MAX;
    slot = recipeOk ? 5'(recipeNumber - 8'h01) : 5'h00;
    posDiff = actualPosition >= activeTarget ? actualPosition - activeTarget
      : activeTarget - actualPosition;
  end
  always_comb begin
    next_state = state;
    next_holdCount = holdCount;
    next_datasetTakenFlag = datasetTakenFlag;
    next_dirOuterFlag = dirOuterFlag;
    next_dirInnerFlag = dirInnerFlag;
    next_partLostMsg = partLostMsg;
    next_faultState = faultState;
    next_moveOuter = moveOuter;
    next_moveInner = moveInner;
    next_forceControlled = forceControlled;
    next_currentHold = currentHold;
    next_relearnBusy = relearnBusy;
    next_activeMode = activeMode;
    next_activeForce = activeForce;
    next_activeWindow = activeWindow;
    next_activeTarget = activeTarget;
    next_slotUsed = slotUsed;
    storeWe = 1'b0;
    captureWe = 1'b0;
    next_partInWindow = {8'h00, activeWindow} >= posDiff;
    if (commandWord == `GPD_CMD_NONE) begin
      next_datasetTakenFlag = 1'b0;
    end
    if (fire) begin
      case (commandWord)
        `GPD_CMD_LOAD: begin
          if (recipeLive) begin
            if (modeLegal(travelModeSelect)) begin
              next_activeMode = travelModeSelect;
            end
            if (forceLegal(forceLevel)) begin
              next_activeForce = forceLevel;
            end
            next_activeWindow = positionWindow;
            next_activeTarget = expectedPartPosition;
            next_datasetTakenFlag = 1'b1;
          end else if (recipeOk && slotUsed[slot]) begin
            next_activeMode = memMode[slot];
            next_activeForce = memForce[slot];
            next_activeWindow = memWindow[slot];
            next_activeTarget = memTarget[slot];
            next_datasetTakenFlag = 1'b1;
          end
        end
        `GPD_CMD_STORE: begin
          // Stored mode and force are checked so a recipe load is always legal
          if (recipeOk && modeLegal(travelModeSelect)
              && forceLegal(forceLevel)) begin
            storeWe = 1'b1;
            next_slotUsed[slot] = 1'b1;
          end
        end
        `GPD_CMD_CLRDIR: begin
          next_dirOuterFlag = 1'b0;
          next_dirInnerFlag = 1'b0;
        end
        `GPD_CMD_CAPTURE: begin
          captureWe = recipeOk && slotUsed[slot];
        end
        `GPD_CMD_RELEARN: begin
          if (state == ST_IDLE) begin
            next_state = ST_RELEARN;
            next_relearnBusy = 1'b1;
          end
        end
        `GPD_CMD_OUTER: begin
          // A repeat toward the flagged side waits for a direction clear
          if (!dirOuterFlag && state != ST_RELEARN) begin
            next_state = ST_MOVE;
            next_moveOuter = 1'b1;
            next_moveInner = 1'b0;
            next_currentHold = 1'b0;
            next_dirOuterFlag = 1'b1;
            next_dirInnerFlag = 1'b0;
            next_forceControlled = activeMode != `GPD_MODE_OUT
              && activeMode != `GPD_MODE_OUT_HOLD;
          end
        end
        `GPD_CMD_INNER: begin
          if (!dirInnerFlag && state != ST_RELEARN) begin
            next_state = ST_MOVE;
            next_moveInner = 1'b1;
            next_moveOuter = 1'b0;
            next_currentHold = 1'b0;
            next_dirInnerFlag = 1'b1;
            next_dirOuterFlag = 1'b0;
            next_forceControlled = activeMode != `GPD_MODE_IN
              && activeMode != `GPD_MODE_IN_HOLD;
          end
        end
        `GPD_CMD_ACK: begin
          next_faultState = faultState & ~RESETTABLE;
          next_partLostMsg = 1'b0;
        end
        default: ;
      endcase
    end
    case (state)
      ST_IDLE: ;
      ST_MOVE: begin
        // Part loss is only reported; the jaws keep going to the end
        if (partLost) begin
          next_partLostMsg = 1'b1;
        end
        if (moveDone && next_state == ST_MOVE) begin
          next_moveOuter = 1'b0;
          next_moveInner = 1'b0;
          if ((moveInner && activeMode == `GPD_MODE_OUT_HOLD)
              || (moveOuter && activeMode == `GPD_MODE_IN_HOLD)
              || activeMode == `GPD_MODE_UNI_HOLD) begin
            next_state = ST_HOLD;
            next_currentHold = 1'b1;
            next_holdCount = 24'(HOLD_CYCLES - 1);
          end else begin
            next_state = ST_IDLE;
          end
        end
      end
      ST_HOLD: begin
        if (next_state == ST_HOLD) begin
          if (holdCount == 24'h000000) begin
            next_state = ST_IDLE;
            next_currentHold = 1'b0;
          end else begin
            next_holdCount = holdCount - 24'h000001;
          end
        end
      end
      ST_RELEARN: begin
        if (relearnDone) begin
          next_state = ST_IDLE;
          next_relearnBusy = 1'b0;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
    // A fault arriving together with an acknowledge stays set
    next_faultState = next_faultState | faultEvent;
  end
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state <= ST_IDLE;
      lastCmd <= `GPD_CMD_NONE;
      holdCount <= 24'h000000;
      datasetTakenFlag <= 1'b0;
      dirOuterFlag <= 1'b0;
      dirInnerFlag <= 1'b0;
      errorFlag <= 1'b0;
      partInWindow <= 1'b0;
      partLostMsg <= 1'b0;
      faultState <= '0;
      moveOuter <= 1'b0;
      moveInner <= 1'b0;
      forceControlled <= 1'b0;
      currentHold <= 1'b0;
      relearnBusy <= 1'b0;
      activeMode <= `GPD_RST_MODE;
      activeForce <= `GPD_RST_FORCE;
      activeWindow <= `GPD_RST_WINDOW;
      activeTarget <= `GPD_RST_TARGET;
      slotUsed <= '0;
    end else begin
      state <= next_state;
      lastCmd <= commandWord;
      holdCount <= next_holdCount;
      datasetTakenFlag <= next_datasetTakenFlag;
      dirOuterFlag <= next_dirOuterFlag;
      dirInnerFlag <= next_dirInnerFlag;
      errorFlag <= |next_faultState;
      partInWindow <= next_partInWindow;
      partLostMsg <= next_partLostMsg;
      faultState <= next_faultState;
      moveOuter <= next_moveOuter;
      moveInner <= next_moveInner;
      forceControlled <= next_forceControlled;
      currentHold <= next_currentHold;
      relearnBusy <= next_relearnBusy;
      activeMode <= next_activeMode;
      activeForce <= next_activeForce;
      activeWindow <= next_activeWindow;
      activeTarget <= next_activeTarget;
      slotUsed <= next_slotUsed;
    end
  end
  // Recipe memory has no reset; slotUsed guards reads of empty slots
  always_ff @(posedge clock) begin
    if (storeWe) begin
      memMode[slot] <= travelModeSelect;
      memForce[slot] <= forceLevel;
      memWindow[slot] <= positionWindow;
      memTarget[slot] <= expectedPartPosition;
    end else if (captureWe) begin
      memTarget[slot] <= actualPosition;
    end
  end
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  logic [23:0] holdRun;
  always_ff @(posedge clock) begin
    if (sys_rst || !currentHold) begin
      holdRun <= 24'h000000;
    end else begin
      holdRun <= holdRun + 24'h000001;
    end
  end
  sequence seqNewWord(logic [15:0] code);
    commandWord == code && lastCmd != code;
  endsequence
  sequence seqLiveLoad;
    seqNewWord(`GPD_CMD_LOAD) and recipeNumber == `GPD_RECIPE_LIVE;
  endsequence
  chk_load_taken: assert property (
    seqLiveLoad ##1 commandWord == `GPD_CMD_NONE |=> !datasetTakenFlag)
    else $error("taken flag not cleared after zero word");
  chk_load_sets: assert property (seqLiveLoad |=> datasetTakenFlag)
    else $error("live load did not set taken flag");
  chk_dir_outer: assert property (
    seqNewWord(`GPD_CMD_OUTER) and !dirOuterFlag and state != ST_RELEARN
    |=> dirOuterFlag && !dirInnerFlag && moveOuter)
    else $error("outer move not started or flagged");
  chk_dir_clear: assert property (
    seqNewWord(`GPD_CMD_CLRDIR) |=> !dirOuterFlag && !dirInnerFlag)
    else $error("direction flag not cleared");
  chk_bad_word: assert property (
    commandWord == (`GPD_CMD_OUTER | `GPD_CMD_INNER) && state == ST_IDLE
    |=> !moveOuter && !moveInner)
    else $error("multi-bit word started a move");
  chk_mode_kept: assert property (
    seqLiveLoad and !modeLegal(travelModeSelect)
    |=> activeMode == $past(activeMode))
    else $error("illegal travel mode was adopted");
  chk_hold_len: assert property (
    currentHold |-> holdRun < 24'(HOLD_CYCLES))
    else $error("current hold ran too long");
  chk_hold_start: assert property (
    state == ST_MOVE && moveDone && moveInner && !fire
    && activeMode == `GPD_MODE_OUT_HOLD |=> currentHold [*2])
    else $error("current hold missing after inner move");
  chk_fault_ack: assert property (
    seqNewWord(`GPD_CMD_ACK) and faultEvent == '0
    |=> faultState == ($past(faultState) & ~RESETTABLE))
    else $error("acknowledge cleared wrong faults");
  chk_force_mode: assert property (
    seqNewWord(`GPD_CMD_OUTER) and !dirOuterFlag and state != ST_RELEARN
    and activeMode == `GPD_MODE_OUT |=> !forceControlled)
    else $error("outer move not at high speed in mode 60");
endmodule

//--- verilog/gpd_map.svh
// Constants of the gripper process data command decoder.
// Assumes inclusion by bare name from the package and the decoder.
`ifndef GPD_MAP_SVH
`define GPD_MAP_SVH

// Command word codes, one bit each, then their mask and the zero word
`define GPD_CMD_LOAD 16'h0001
`define GPD_CMD_STORE 16'h0002
`define GPD_CMD_CLRDIR 16'h0004
`define GPD_CMD_CAPTURE 16'h0008
`define GPD_CMD_RELEARN 16'h0080
`define GPD_CMD_OUTER 16'h0100
`define GPD_CMD_INNER 16'h0200
`define GPD_CMD_ACK 16'h8000
`define GPD_CMD_MASK 16'h838F
`define GPD_CMD_NONE 16'h0000

// Travel modes (decimal 60, 63, 70, 73, 100, 103)
`define GPD_MODE_OUT 8'h3C
`define GPD_MODE_OUT_HOLD 8'h3F
`define GPD_MODE_IN 8'h46
`define GPD_MODE_IN_HOLD 8'h49
`define GPD_MODE_UNI 8'h64
`define GPD_MODE_UNI_HOLD 8'h67

// Recipe and force ranges
`define GPD_RECIPE_LIVE 8'h00
`define GPD_RECIPE_MAX 8'h20
`define GPD_RECIPE_SLOTS 32
`define GPD_FORCE_MIN 8'h01
`define GPD_FORCE_MAX 8'h04

// Reset values of the active data set
`define GPD_RST_MODE 8'h3C
`define GPD_RST_FORCE 8'h01
`define GPD_RST_WINDOW 8'h00
`define GPD_RST_TARGET 16'h0000

// Current hold after a move
`define GPD_HOLD_MS 500
`define GPD_CLK_KHZ 20000
`define GPD_HOLD_CYCLES (`GPD_HOLD_MS * `GPD_CLK_KHZ)

`endif

//--- verilog/gpd_pkg.sv
// Types of the gripper process data command decoder.
// Assumes gpd_map.svh is on the include path.
`include "gpd_map.svh"

package gpd_pkg;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_MOVE = 4'h2,
    ST_HOLD = 4'h4,
    ST_RELEARN = 4'h8
  } gpd_state_t;

endpackage

//--- testbench/gpd_plc_model.sv
// Controller model: presents the cyclic process data to the decoder.
// Assumes callers enter its tasks just after a rising clock edge.
`timescale 1ns/10ps
`include "gpd_map.svh"

module gpd_plc_model (
  // Clock
  input wire logic clock,
  // Cyclic process data
  output logic [15:0] commandWord,
  output logic [7:0] travelModeSelect,
  output logic [7:0] recipeNumber,
  output logic [7:0] positionWindow,
  output logic [7:0] forceLevel,
  output logic [15:0] expectedPartPosition
);
  initial begin
    commandWord = `GPD_CMD_NONE;
    travelModeSelect = `GPD_MODE_OUT;
    recipeNumber = `GPD_RECIPE_LIVE;
    positionWindow = 8'h00;
    forceLevel = `GPD_FORCE_MIN;
    expectedPartPosition = 16'h0000;
  end

  // Values move one step after the edge, so each stands a full cycle
  task automatic step();
    @(posedge clock);
    #1;
  endtask

  // Listed modes and force 1 to 4 only, except in refusal scenarios
  task automatic setData(input logic [7:0] mode, input logic [7:0] recipe,
      input logic [7:0] window, input logic [7:0] frc,
      input logic [15:0] target);
    travelModeSelect = mode;
    recipeNumber = recipe;
    positionWindow = window;
    forceLevel = frc;
    expectedPartPosition = target;
  endtask

  // One code or zero per cycle; a word only acts when it changes
  task automatic sendCmd(input logic [15:0] word);
    commandWord = word;
    step();
  endtask
endmodule

//--- testbench/tb_top.sv
// Self-checking bench for the process data command decoder.
// Assumes the controller model drives the process data fields.
`timescale 1ns/10ps
`include "gpd_map.svh"

module tb_top;
  localparam int HOLD = 20;
  logic clock = 1'b0;
  logic sysRst = 1'b1;
  logic [15:0] commandWord, expectedPartPosition, activeTarget;
  logic [7:0] travelModeSelect, recipeNumber, positionWindow, forceLevel;
  logic [15:0] actualPosition = 16'h0000;
  logic moveDone = 1'b0;
  logic relearnDone = 1'b0;
  logic partLost = 1'b0;
  logic [7:0] faultEvent = 8'h00;
  logic datasetTakenFlag, dirOuterFlag, dirInnerFlag, errorFlag;
  logic partInWindow, partLostMsg, moveOuter, moveInner;
  logic forceControlled, currentHold, relearnBusy;
  logic [7:0] faultState, activeMode, activeForce, activeWindow;
  logic [7:0] modes [6] = '{`GPD_MODE_OUT, `GPD_MODE_OUT_HOLD,
    `GPD_MODE_IN, `GPD_MODE_IN_HOLD, `GPD_MODE_UNI, `GPD_MODE_UNI_HOLD};
  logic [15:0] winPos [4] = '{16'h0110, 16'h0111, 16'h00F0, 16'h00EF};
  logic [15:0] badCmd [3] = '{16'h0300, 16'h0010, 16'h0081};
  int mismatches = 0;
  int cmp_count = 0;

  always #25 clock = ~clock;

  gpd_plc_model gpd_plc_model_i (
    .clock, .commandWord, .travelModeSelect, .recipeNumber,
    .positionWindow, .forceLevel, .expectedPartPosition
  );

  gpd_command_decoder #(.HOLD_CYCLES(HOLD)) gpd_command_decoder_i (
    .clock, .sys_rst(sysRst), .commandWord, .travelModeSelect,
    .recipeNumber, .positionWindow, .forceLevel, .expectedPartPosition,
    .actualPosition, .moveDone, .relearnDone, .partLost, .faultEvent,
    .datasetTakenFlag, .dirOuterFlag, .dirInnerFlag, .errorFlag,
    .partInWindow, .partLostMsg, .faultState, .moveOuter, .moveInner,
    .forceControlled, .currentHold, .relearnBusy, .activeMode,
    .activeForce, .activeWindow, .activeTarget
  );

  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
      input string msg);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: %s got %h want %h", $time, msg, got, exp);
    end
  endtask

  task automatic step();
    gpd_plc_model_i.step();
  endtask

  task automatic cmd(input logic [15:0] word);
    gpd_plc_model_i.sendCmd(word);
  endtask

  task automatic load(input logic [7:0] mode, input logic [7:0] recipe,
      input logic [7:0] window, input logic [7:0] frc,
      input logic [15:0] target);
    gpd_plc_model_i.setData(mode, recipe, window, frc, target);
    cmd(`GPD_CMD_LOAD);
  endtask

  // Ends a move and measures the current hold, bounded in cycles
  task automatic finishMove(input logic expHold);
    int n;
    n = 0;
    moveDone = 1'b1;
    cmd(`GPD_CMD_NONE);
    moveDone = 1'b0;
    chk({moveOuter, moveInner}, 2'b00, "move stops at end");
    chk(currentHold, expHold, "hold starts");
    while (currentHold !== 1'b0 && n < 40) begin
      step();
      n++;
    end
    if (n == 40) begin
      mismatches++;
      $display("mismatch at %0t: hold never ended", $time);
      tally_and_finish();
    end
    chk(16'(n), expHold ? 16'(HOLD) : 16'h0, "hold length");
  endtask

  initial begin
    logic [7:0] m;
    logic fcExp;
    logic holdExp;
    repeat (8) step();
    sysRst = 1'b0;
    chk(activeMode, `GPD_RST_MODE, "reset mode");
    chk(activeForce, `GPD_RST_FORCE, "reset force");
    load(`GPD_MODE_IN, 8'h00, 8'h10, 8'h03, 16'h0100);
    chk(activeMode, `GPD_MODE_IN, "live mode");
    chk(activeForce, 8'h03, "live force");
    chk(activeTarget, 16'h0100, "live target");
    chk(datasetTakenFlag, 1'b1, "taken set");
    cmd(`GPD_CMD_NONE);
    chk(datasetTakenFlag, 1'b0, "taken cleared");
    foreach (winPos[k]) begin
      actualPosition = winPos[k];
      step();
      step();
      chk(partInWindow, k % 2 == 0, "window edge");
    end
    load(8'h41, 8'h00, 8'h10, 8'h02, 16'h0100);
    chk(activeMode, `GPD_MODE_IN, "bad mode kept old");
    chk(activeForce, 8'h02, "force beside bad mode");
    cmd(`GPD_CMD_NONE);
    load(`GPD_MODE_OUT, 8'h00, 8'h10, 8'h05, 16'h0100);
    chk(activeForce, 8'h02, "bad force kept old");
    cmd(`GPD_CMD_NONE);
    gpd_plc_model_i.setData(`GPD_MODE_UNI, 8'h05, 8'h20, 8'h04, 16'h0200);
    cmd(`GPD_CMD_STORE);
    cmd(`GPD_CMD_NONE);
    load(`GPD_MODE_OUT, 8'h05, 8'h00, 8'h01, 16'h0000);
    chk(activeMode, `GPD_MODE_UNI, "recipe mode");
    chk(activeWindow, 8'h20, "recipe window");
    chk(activeTarget, 16'h0200, "recipe target");
    cmd(`GPD_CMD_NONE);
    load(`GPD_MODE_OUT, 8'h21, 8'h00, 8'h01, 16'h0000);
    chk(datasetTakenFlag, 1'b0, "recipe 33 refused");
    actualPosition = 16'h0333;
    gpd_plc_model_i.setData(`GPD_MODE_OUT, 8'h00, 8'h00, 8'h01, 16'h0000);
    cmd(`GPD_CMD_CAPTURE);
    chk(activeTarget, 16'h0200, "capture at recipe 0");
    gpd_plc_model_i.setData(`GPD_MODE_OUT, 8'h05, 8'h00, 8'h01, 16'h0000);
    cmd(`GPD_CMD_NONE);
    cmd(`GPD_CMD_CAPTURE);
    cmd(`GPD_CMD_LOAD);
    chk(activeTarget, 16'h0333, "captured target");
    cmd(`GPD_CMD_NONE);
    for (int i = 0; i < 6; i++) begin
      m = modes[i];
      load(m, 8'h00, 8'h10, 8'h02, 16'h0100);
      chk(activeMode, m, "mode taken");
      cmd(`GPD_CMD_NONE);
      for (int d = 0; d < 2; d++) begin
        fcExp = (m == `GPD_MODE_UNI || m == `GPD_MODE_UNI_HOLD) ? 1'b1 :
          (m == `GPD_MODE_OUT || m == `GPD_MODE_OUT_HOLD) ? d == 1 : d == 0;
        holdExp = m == `GPD_MODE_UNI_HOLD ||
          (m == `GPD_MODE_OUT_HOLD && d == 1) ||
          (m == `GPD_MODE_IN_HOLD && d == 0);
        cmd(d == 0 ? `GPD_CMD_OUTER : `GPD_CMD_INNER);
        chk({moveOuter, moveInner}, d == 0 ? 2'b10 : 2'b01, "move");
        chk({dirOuterFlag, dirInnerFlag}, d == 0 ? 2'b10 : 2'b01, "dir");
        chk(forceControlled, fcExp, "speed profile");
        if (i == 0 && d == 0) begin
          partLost = 1'b1;
          step();
          partLost = 1'b0;
          step();
          chk(moveOuter, 1'b1, "move goes on");
          chk(partLostMsg, 1'b1, "loss reported");
        end
        finishMove(holdExp);
      end
    end
    cmd(`GPD_CMD_INNER);
    chk(moveInner, 1'b0, "repeat move refused");
    cmd(`GPD_CMD_CLRDIR);
    chk(dirInnerFlag, 1'b0, "direction cleared");
    cmd(`GPD_CMD_INNER);
    chk(moveInner, 1'b1, "repeat move after clear");
    finishMove(1'b1);
    foreach (badCmd[k]) begin
      cmd(badCmd[k]);
      chk({moveOuter, moveInner, relearnBusy}, 3'b000, "bad word");
      cmd(`GPD_CMD_NONE);
    end
    faultEvent = 8'hFF;
    step();
    faultEvent = 8'h00;
    step();
    chk(faultState, 8'hFF, "faults latched");
    cmd(`GPD_CMD_ACK);
    chk(faultState, 8'h80, "resettable cleared");
    chk(errorFlag, 1'b1, "fixed fault remains");
    chk(partLostMsg, 1'b0, "loss message cleared");
    cmd(`GPD_CMD_RELEARN);
    chk(relearnBusy, 1'b1, "relearn runs");
    relearnDone = 1'b1;
    cmd(`GPD_CMD_NONE);
    relearnDone = 1'b0;
    chk(relearnBusy, 1'b0, "relearn ends");
    tally_and_finish();
  end
endmodule
